// ---- teac_pkg.sv ----
package teac_pkg;
    // register byte addresses on the first programming page
    localparam logic [11:0] CTRL_OFFSET      = 12'h020;
    localparam logic [11:0] ACK_OFFSET       = 12'h024;
    localparam logic [11:0] BYPASS_OFFSET    = 12'h044;
    localparam logic [11:0] STATUS_OFFSET    = 12'h048;

    // field positions shared by control and acknowledge words; the abort bit sits in the bypass word
    localparam int EN_BIT    = 0;
    localparam int PRIQ_BIT  = 1;
    localparam int EVTQ_BIT  = 2;
    localparam int CMDQ_BIT  = 3;
    localparam int ATS_CHECK_BIT = 4;
    localparam int WILDCARD_LSB  = 6;
    localparam int WALK_BIT  = 10;
    localparam int ABORT_BIT = 20;

    // writable masks and reset values
    localparam logic [31:0] CTRL_MASK        = 32'h0000_05DF;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
    localparam logic [31:0] BYPASS_MASK      = 32'h001F_FFFF;
    localparam logic [31:0] BYPASS_RESET     = 32'h0010_0000;

    // vmid wildcard codes above this act as zero
    localparam logic [2:0]  WILDCARD_MAX     = 3'h4;

    // minimum drain before an enable update, given in ns and converted to clock cycles
    localparam int          DRAIN_TIME_NS    = 64;
    localparam int          CLK_PERIOD_NS    = 8;
    localparam logic [3:0]  DRAIN_CYCLES     = 4'(DRAIN_TIME_NS / CLK_PERIOD_NS);

    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // transaction disposition
    typedef enum logic [1:0] {
        TEAC_TRANSLATE,
        TEAC_BYPASS,
        TEAC_ABORT
    } teac_route_e;

    typedef enum logic [1:0] {
        TEAC_IDLE,
        TEAC_DRAIN,
        TEAC_ACK
    } teac_state_e;

    // stall tag release event
    typedef struct packed {
        logic       valid;
        logic [7:0] tag;
    } teac_tag_s;
endpackage : teac_pkg

// ---- teac_ctrl.sv ----
// Overview of operation
// - enable off and abort bit clear: pass transactions untranslated with bypass attributes.
// - enable off and abort bit set: abort every matching transaction.
// - secure and non-secure enables never affect each other's traffic.
// - enable off: answer ATS translation requests with unsupported request.
// - enable off: ignore ATC invalidate and PRI response, drop page requests.
// - enable off: abort ATS translated transactions.
// - enable off: no stream table reads, stream table config ignored.
// - enable off: no cache inserts, invalidations still allowed.
// - enable off: prefetch commands fetch nothing and fill nothing.
// - enable off: no hardware table update, no speculative access flag.
// - enable off: no translation events, no software translation operations.
// - enable off: commands and events follow only their own queue enables.
// - enable on acknowledged: secondary control applied, table routing, run flags clear.
// - disable acknowledged: stalls marked for abort, no new stalls.
// - each stall hit by disable releases its stall tag.
// - disable waits for translation operations to finish or fail with internal error.
// - disable acknowledged: page request enable off, new traffic bypasses.
// - each transaction sees one enable value only.
// - ordering kept; after acknowledge all new traffic uses new value.
// - enable change does not force cache invalidation.
// - acknowledge bit 10 reports walk enable when implemented, else zero.
// - wildcard code 0 to 4 ignores that many low VMID bits on invalidation.
// - ats check bit 4: 0 fast pass, 1 check stream ats permission.
// - fields mirror into acknowledge once their update completes.
// - acknowledge register decoded at byte offset 0x0024.
`timescale 1ns/1ns
`default_nettype none
module teac_ctrl #(
    parameter bit WALK_IMPL = 1'b1
) (
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    // axi4-lite slave
    input  wire logic [11:0]       S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [11:0]       S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // transaction entry from upstream, non-secure streams
    input  wire logic              TXN_VALID,
    input  wire logic              TXN_ATS_TRANSLATED,
    output teac_pkg::teac_route_e  TXN_ROUTE,
    output logic [19:0]            TXN_BYPASS_ATTR,
    input  wire logic              ATS_REQ_VALID,
    output logic                   ATS_REQ_UNSUPPORTED,
    input  wire logic              PAGE_REQ_VALID,
    output logic                   PAGE_REQ_DISCARD,
    // engine permissions and status
    output logic                   STREAM_TABLE_ENABLE,
    output logic                   CACHE_FILL_ENABLE,
    output logic                   HW_TABLE_UPDATE_ENABLE,
    output logic                   TRANSLATION_EVENT_ENABLE,
    output logic                   ATS_CMD_ENABLE,
    output logic                   STALL_ENABLE,
    output logic                   STALL_ABORT_ALL,
    output logic                   COMMAND_QUEUE_ENABLE,
    output logic                   EVENT_QUEUE_ENABLE,
    output logic                   PAGE_REQUEST_QUEUE_ENABLE,
    output logic                   TRANSLATION_OPERATION_ENABLE,
    output logic                   TRANSLATION_OPERATION_ABORT,
    input  wire logic              TRANSLATION_OPERATION_BUSY,
    input  wire logic              ENGINE_IDLE,
    input  wire teac_pkg::teac_tag_s STALL_TAG_IN,
    output teac_pkg::teac_tag_s    STALL_TAG_RELEASE,
    output logic [2:0]             VMID_WILDCARD_BITS,
    output logic                   ATS_CHECK_MODE,
    output logic                   WALK_ENABLE
);
    logic [31:0] ctrl;
    logic [31:0] ack;
    logic [31:0] bypass;
    logic        en_eff;
    teac_pkg::teac_state_e state;
    logic [3:0]  drain_cnt;
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;

    // every check below runs on the one device clock and sleeps in reset
    default clocking dflt_cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    // byte-lane merge of a write into a register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : merge

    // ---- write channel: address and data taken in either order
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
    assign wr_fire = aw_held && w_held;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // write response; unmapped or read-only addresses answer slverr
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= teac_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            if (aw_addr[11:2] == teac_pkg::CTRL_OFFSET[11:2]) begin
                S_AXI_BRESP <= teac_pkg::RESP_OKAY;
            end else if (aw_addr[11:2] == teac_pkg::BYPASS_OFFSET[11:2]) begin
                S_AXI_BRESP <= teac_pkg::RESP_OKAY;
            end else begin
                S_AXI_BRESP <= teac_pkg::RESP_SLVERR;
            end
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // software control words; ack is never written by the bus
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl   <= teac_pkg::CTRL_RESET;
            bypass <= teac_pkg::BYPASS_RESET;
        end else if (wr_fire) begin
            if (aw_addr[11:2] == teac_pkg::CTRL_OFFSET[11:2]) begin
                ctrl <= merge(ctrl, w_data, w_strb, teac_pkg::CTRL_MASK);
            end else if (aw_addr[11:2] == teac_pkg::BYPASS_OFFSET[11:2]) begin
                bypass <= merge(bypass, w_data, w_strb, teac_pkg::BYPASS_MASK);
            end
        end
    end

    // ---- read channel
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= teac_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= teac_pkg::RESP_OKAY;
            if (S_AXI_ARADDR[11:2] == teac_pkg::CTRL_OFFSET[11:2]) begin
                S_AXI_RDATA <= ctrl;
            end else if (S_AXI_ARADDR[11:2] == teac_pkg::ACK_OFFSET[11:2]) begin
                S_AXI_RDATA <= ack;
            end else if (S_AXI_ARADDR[11:2] == teac_pkg::BYPASS_OFFSET[11:2]) begin
                S_AXI_RDATA <= bypass;
            end else if (S_AXI_ARADDR[11:2] == teac_pkg::STATUS_OFFSET[11:2]) begin
                S_AXI_RDATA <= {30'h0000_0000, state == teac_pkg::TEAC_DRAIN, en_eff};
            end else begin
                S_AXI_RDATA <= 32'h0000_0000;
                S_AXI_RRESP <= teac_pkg::RESP_SLVERR;
            end
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ---- enable update sequencer
    // a disable must drain stalls and translation operations before the ack; enable waits for
    // the fixed drain so secondary control settings are in place
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state     <= teac_pkg::TEAC_IDLE;
            drain_cnt <= 4'h0;
            en_eff    <= 1'b0;
        end else begin
            case (state)
                teac_pkg::TEAC_IDLE: begin
                    if (ctrl[teac_pkg::EN_BIT] != ack[teac_pkg::EN_BIT]) begin
                        state     <= teac_pkg::TEAC_DRAIN;
                        drain_cnt <= teac_pkg::DRAIN_CYCLES;
                    end
                end
                teac_pkg::TEAC_DRAIN: begin
                    if (drain_cnt != 4'h0) begin
                        drain_cnt <= drain_cnt - 4'h1;
                    end else if (ENGINE_IDLE && !TRANSLATION_OPERATION_BUSY) begin
                        // switch point: every later arrival sees the new value
                        en_eff <= ack[teac_pkg::EN_BIT] ^ 1'b1;
                        state  <= teac_pkg::TEAC_ACK;
                    end
                end
                teac_pkg::TEAC_ACK: begin
                    state <= teac_pkg::TEAC_IDLE;
                end
                default: begin
                    state <= teac_pkg::TEAC_IDLE;
                end
            endcase
        end
    end

    // acknowledge mirror; other fields update one cycle after writing
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ack <= 32'h0000_0000;
        end else begin
            ack[teac_pkg::PRIQ_BIT]   <= ctrl[teac_pkg::PRIQ_BIT];
            ack[teac_pkg::EVTQ_BIT]   <= ctrl[teac_pkg::EVTQ_BIT];
            ack[teac_pkg::CMDQ_BIT]   <= ctrl[teac_pkg::CMDQ_BIT];
            ack[teac_pkg::ATS_CHECK_BIT] <= ctrl[teac_pkg::ATS_CHECK_BIT];
            ack[teac_pkg::WILDCARD_LSB +: 3] <= ctrl[teac_pkg::WILDCARD_LSB +: 3];
            ack[teac_pkg::WALK_BIT]   <= WALK_IMPL & ctrl[teac_pkg::WALK_BIT];
            if (state == teac_pkg::TEAC_ACK) begin
                ack[teac_pkg::EN_BIT] <= en_eff;
            end
        end
    end

    // transaction routing from the one effective value, non-secure only
    always_comb begin
        TXN_ROUTE = teac_pkg::TEAC_TRANSLATE;
        if (!en_eff) begin
            if (bypass[teac_pkg::ABORT_BIT] || TXN_ATS_TRANSLATED) begin
                TXN_ROUTE = teac_pkg::TEAC_ABORT;
            end else begin
                TXN_ROUTE = teac_pkg::TEAC_BYPASS;
            end
        end
    end

    // bypass attributes, registered
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            TXN_BYPASS_ATTR <= 20'h00000;
        end else begin
            TXN_BYPASS_ATTR <= bypass[19:0];
        end
    end

    // ats and page request interface shut while off
    assign ATS_REQ_UNSUPPORTED       = ATS_REQ_VALID && !en_eff;
    assign PAGE_REQ_DISCARD          = PAGE_REQ_VALID && !en_eff;
    assign ATS_CMD_ENABLE            = en_eff;
    assign PAGE_REQUEST_QUEUE_ENABLE = en_eff && ack[teac_pkg::PRIQ_BIT];

    // walk, cache and update permissions; invalidation is never gated
    assign STREAM_TABLE_ENABLE      = en_eff;
    assign CACHE_FILL_ENABLE        = en_eff;
    assign HW_TABLE_UPDATE_ENABLE   = en_eff;
    assign TRANSLATION_EVENT_ENABLE = en_eff;
    assign TRANSLATION_OPERATION_ENABLE = en_eff && state == teac_pkg::TEAC_IDLE;
    assign TRANSLATION_OPERATION_ABORT  = state == teac_pkg::TEAC_DRAIN && ack[teac_pkg::EN_BIT];

    // queues follow only their own enables
    assign COMMAND_QUEUE_ENABLE = ack[teac_pkg::CMDQ_BIT];
    assign EVENT_QUEUE_ENABLE   = ack[teac_pkg::EVTQ_BIT];

    // stalls: none while off or draining to off
    assign STALL_ENABLE    = en_eff && !(state != teac_pkg::TEAC_IDLE && ack[teac_pkg::EN_BIT]);
    assign STALL_ABORT_ALL = !STALL_ENABLE;

    // tag of each aborted stall goes back to the free pool
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            STALL_TAG_RELEASE <= '0;
        end else begin
            STALL_TAG_RELEASE.valid <= STALL_TAG_IN.valid && STALL_ABORT_ALL;
            STALL_TAG_RELEASE.tag   <= STALL_TAG_IN.tag;
        end
    end

    // reserved wildcard codes act as exact match; lookups ignore this
    assign VMID_WILDCARD_BITS = (ack[teac_pkg::WILDCARD_LSB +: 3] > teac_pkg::WILDCARD_MAX) ? 3'h0
                                : ack[teac_pkg::WILDCARD_LSB +: 3];
    assign ATS_CHECK_MODE = ack[teac_pkg::ATS_CHECK_BIT];
    assign WALK_ENABLE    = ack[teac_pkg::WALK_BIT];

    // ---- checks
    AST_ACK_EN_AFTER_SWITCH: assert property (@(posedge CLK) disable iff (SYS_RST)
        state == teac_pkg::TEAC_ACK |=> ack[teac_pkg::EN_BIT] == en_eff)
        else $error("ack enable not mirrored");
    AST_ABORT_ROUTE: assert property (@(posedge CLK) disable iff (SYS_RST)
        !en_eff && bypass[teac_pkg::ABORT_BIT] |-> TXN_ROUTE == teac_pkg::TEAC_ABORT)
        else $error("abort not applied");
    AST_BYPASS_ROUTE: assert property (@(posedge CLK) disable iff (SYS_RST)
        !en_eff && !bypass[teac_pkg::ABORT_BIT] && !TXN_ATS_TRANSLATED |-> TXN_ROUTE == teac_pkg::TEAC_BYPASS)
        else $error("bypass not applied");
    AST_ATS_UR: assert property (@(posedge CLK) disable iff (SYS_RST)
        ATS_REQ_VALID && !ack[teac_pkg::EN_BIT] && state == teac_pkg::TEAC_IDLE |-> ATS_REQ_UNSUPPORTED)
        else $error("ats request not refused");
    AST_NO_WALK_OFF: assert property (@(posedge CLK) disable iff (SYS_RST)
        !en_eff |-> !STREAM_TABLE_ENABLE && !CACHE_FILL_ENABLE && !HW_TABLE_UPDATE_ENABLE)
        else $error("walk while off");
    AST_DISABLE_DRAINED: assert property (@(posedge CLK) disable iff (SYS_RST)
        $fell(en_eff) |-> $past(!TRANSLATION_OPERATION_BUSY) && $past(ENGINE_IDLE))
        else $error("disable before drain");
    AST_NO_STALL_OFF: assert property (@(posedge CLK) disable iff (SYS_RST)
        !ack[teac_pkg::EN_BIT] && state == teac_pkg::TEAC_IDLE |-> !STALL_ENABLE)
        else $error("stall allowed while off");
    AST_ACK_RESERVED: assert property (@(posedge CLK) disable iff (SYS_RST)
        ack[31:11] == 21'h000000 && ack[9] == 1'b0 && ack[5] == 1'b0)
        else $error("reserved ack bit set");
    AST_WILDCARD_MIRROR: assert property (@(posedge CLK) disable iff (SYS_RST)
        ##1 ack[teac_pkg::WILDCARD_LSB +: 3] == $past(ctrl[teac_pkg::WILDCARD_LSB +: 3]))
        else $error("wildcard not mirrored");

    // switch reaches the ack one cycle later, then the mirror has settled
    sequence s_switch;
        state == teac_pkg::TEAC_DRAIN && drain_cnt == 4'h0 && ENGINE_IDLE && !TRANSLATION_OPERATION_BUSY;
    endsequence : s_switch
    sequence s_ack_done;
        state == teac_pkg::TEAC_ACK ##1 state == teac_pkg::TEAC_IDLE && ack[teac_pkg::EN_BIT] == en_eff;
    endsequence : s_ack_done
    AST_SWITCH_ACK: assert property (s_switch |=> s_ack_done)
        else $error("switch not acknowledged");

    // shut paths while off; the enable mirror moves only at the ack
    AST_PAGE_DISCARD: assert property (
        PAGE_REQ_VALID && !en_eff |-> PAGE_REQ_DISCARD && !PAGE_REQUEST_QUEUE_ENABLE && !ATS_CMD_ENABLE)
        else $error("page request kept while off");
    AST_TRANSLATED_ABORT: assert property (
        !en_eff && TXN_ATS_TRANSLATED |-> TXN_ROUTE == teac_pkg::TEAC_ABORT)
        else $error("translated traffic passed while off");
    AST_NO_EVENT_OFF: assert property (
        !en_eff |-> !TRANSLATION_EVENT_ENABLE && !TRANSLATION_OPERATION_ENABLE)
        else $error("events or operations while off");
    AST_TRANSLATE_ON: assert property (
        en_eff |-> TXN_ROUTE == teac_pkg::TEAC_TRANSLATE)
        else $error("bypass while on");
    AST_TAG_RELEASE: assert property (
        STALL_TAG_IN.valid && STALL_ABORT_ALL |=> STALL_TAG_RELEASE.valid && STALL_TAG_RELEASE.tag == $past(STALL_TAG_IN.tag))
        else $error("stall tag not released");
    AST_DRAIN_ABORTS: assert property (
        state == teac_pkg::TEAC_DRAIN && ack[teac_pkg::EN_BIT] |-> TRANSLATION_OPERATION_ABORT && STALL_ABORT_ALL)
        else $error("disable drain without abort");
    AST_ACK_EN_AT_SWITCH: assert property (
        $changed(ack[teac_pkg::EN_BIT]) |-> $past(state) == teac_pkg::TEAC_ACK)
        else $error("enable mirror moved outside ack");
    AST_WILDCARD_RANGE: assert property (
        VMID_WILDCARD_BITS <= teac_pkg::WILDCARD_MAX)
        else $error("reserved wildcard code used");
endmodule : teac_ctrl
`default_nettype wire

// ---- teac_engine_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// stands in for the walk engine and the store of stalled transactions
module teac_engine_model #(
    parameter logic [7:0] STALL_TAG = 8'h5A
) (
    input  wire logic            CLK,
    input  wire logic            SYS_RST,
    input  wire logic            START_OP,
    input  wire logic            STALL_REQ,
    input  wire logic            TRANSLATION_OPERATION_ABORT,
    input  wire logic            STALL_ABORT_ALL,
    output logic                 TRANSLATION_OPERATION_BUSY,
    output logic                 ENGINE_IDLE,
    output teac_pkg::teac_tag_s  STALL_TAG_IN
);
    logic [2:0] fail_cnt;
    logic       stall_held;

    // an operation fails only some cycles after the abort, so the ack must wait
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            TRANSLATION_OPERATION_BUSY <= 1'b0;
            fail_cnt <= 3'h0;
        end else if (START_OP) begin
            TRANSLATION_OPERATION_BUSY <= 1'b1;
        end else if (TRANSLATION_OPERATION_ABORT && TRANSLATION_OPERATION_BUSY) begin
            fail_cnt <= fail_cnt + 3'h1;
            if (fail_cnt == 3'h4) begin
                TRANSLATION_OPERATION_BUSY <= 1'b0;
            end
        end
    end

    assign ENGINE_IDLE = !TRANSLATION_OPERATION_BUSY;

    // one held stall, its tag offered once; tag toggles when not valid
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            stall_held <= 1'b0;
            STALL_TAG_IN <= '0;
        end else begin
            if (STALL_REQ) begin
                stall_held <= 1'b1;
            end
            STALL_TAG_IN.valid <= stall_held && STALL_ABORT_ALL;
            if (stall_held && STALL_ABORT_ALL) begin
                stall_held <= 1'b0;
                STALL_TAG_IN.tag <= STALL_TAG;
            end else begin
                STALL_TAG_IN.tag <= ~STALL_TAG_IN.tag;
            end
        end
    end
endmodule : teac_engine_model
`default_nettype wire

// ---- test_translation_enable_and_ack_control.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_translation_enable_and_ack_control;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic ats_tr, ats_req, page_req, start_op, stall_req, ats_unsup, page_disc, st_en, cf_en, hw_en, ev_en;
    logic atscmd_en, stall_en, stall_abort, cmdq_en, evtq_en, priq_en, op_en, op_abort, op_busy, eng_idle;
    logic ats_check, walk, abort_seen;
    logic [2:0] vmid_wc;
    logic [7:0] perm, rel_tag;
    logic [31:0] d;
    teac_pkg::teac_route_e route;
    teac_pkg::teac_tag_s tag_in, tag_rel;
    logic [19:0] attr;
    int miscompares, check_count, rel_count;

    teac_ctrl #(.WALK_IMPL(1'b1)) i_teac_ctrl (
        .CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TXN_VALID(1'b1), .TXN_ATS_TRANSLATED(ats_tr),
        .TXN_ROUTE(route), .TXN_BYPASS_ATTR(attr), .ATS_REQ_VALID(ats_req), .ATS_REQ_UNSUPPORTED(ats_unsup),
        .PAGE_REQ_VALID(page_req), .PAGE_REQ_DISCARD(page_disc), .STREAM_TABLE_ENABLE(st_en),
        .CACHE_FILL_ENABLE(cf_en), .HW_TABLE_UPDATE_ENABLE(hw_en), .TRANSLATION_EVENT_ENABLE(ev_en),
        .ATS_CMD_ENABLE(atscmd_en), .STALL_ENABLE(stall_en), .STALL_ABORT_ALL(stall_abort),
        .COMMAND_QUEUE_ENABLE(cmdq_en), .EVENT_QUEUE_ENABLE(evtq_en), .PAGE_REQUEST_QUEUE_ENABLE(priq_en),
        .TRANSLATION_OPERATION_ENABLE(op_en), .TRANSLATION_OPERATION_ABORT(op_abort),
        .TRANSLATION_OPERATION_BUSY(op_busy), .ENGINE_IDLE(eng_idle), .STALL_TAG_IN(tag_in),
        .STALL_TAG_RELEASE(tag_rel), .VMID_WILDCARD_BITS(vmid_wc), .ATS_CHECK_MODE(ats_check), .WALK_ENABLE(walk)
    );

    teac_engine_model i_teac_engine_model (
        .CLK(clk), .SYS_RST(rst), .START_OP(start_op), .STALL_REQ(stall_req),
        .TRANSLATION_OPERATION_ABORT(op_abort), .STALL_ABORT_ALL(stall_abort),
        .TRANSLATION_OPERATION_BUSY(op_busy), .ENGINE_IDLE(eng_idle), .STALL_TAG_IN(tag_in)
    );

    // engine permissions gathered for one compare
    assign perm = {ats_unsup, page_disc, st_en, cf_en, hw_en, ev_en, atscmd_en, op_en};

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // inputs change by nba right after an edge; #1 lets the edge's updates land
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({31'h0, bvalid}, 32'h1);
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        v = rdata;
        chk({31'h0, rvalid}, 32'h1);
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd

    // software polls the mirrored enable; bounded so a stuck update fails
    task automatic poll(input logic want);
        logic [31:0] v;
        int n;
        n = 0;
        do begin
            rd(teac_pkg::ACK_OFFSET, v, teac_pkg::RESP_OKAY);
            n++;
        end while (v[0] !== want && n < 200);
        chk({31'h0, v[0]}, {31'h0, want});
    endtask : poll

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // watches released stall tags and the operation abort
    always @(posedge clk) begin
        if (tag_rel.valid === 1'b1) begin
            rel_count++;
            rel_tag = tag_rel.tag;
        end
        if (op_abort === 1'b1) abort_seen = 1'b1;
    end

    initial begin
        #400000;
        miscompares++;
        test_done;
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, ats_tr, start_op, stall_req, abort_seen} = '0;
        {ats_req, page_req, miscompares, check_count, rel_count, rel_tag} = {2'h3, 104'h0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        chk(route, teac_pkg::TEAC_ABORT);
        chk(perm, 8'hC0);
        rd(teac_pkg::ACK_OFFSET, d, teac_pkg::RESP_OKAY);
        chk(d, 32'h0);
        rd(teac_pkg::BYPASS_OFFSET, d, teac_pkg::RESP_OKAY);
        chk(d, teac_pkg::BYPASS_RESET);
        $display("test reset done");
        wr(teac_pkg::BYPASS_OFFSET, 32'h0000_ABCD, teac_pkg::RESP_OKAY);
        settle(2);
        chk(route, teac_pkg::TEAC_BYPASS);
        chk(attr, 20'hABCD);
        @(posedge clk);
        ats_tr <= 1'b1;
        settle(1);
        chk(route, teac_pkg::TEAC_ABORT);
        @(posedge clk);
        ats_tr <= 1'b0;
        wr(teac_pkg::CTRL_OFFSET, 32'h0000_000C, teac_pkg::RESP_OKAY);
        settle(2);
        chk({cmdq_en, evtq_en, st_en}, 3'h6);
        $display("test bypass done");
        wr(teac_pkg::CTRL_OFFSET, 32'h0000_04DF, teac_pkg::RESP_OKAY);
        poll(1'b1);
        rd(teac_pkg::ACK_OFFSET, d, teac_pkg::RESP_OKAY);
        chk(d, 32'h0000_04DF);
        settle(0);
        chk(route, teac_pkg::TEAC_TRANSLATE);
        chk(perm, 8'h3F);
        chk({priq_en, stall_en, stall_abort, ats_check, walk, vmid_wc}, 8'hDB);
        for (int c = 0; c < 8; c++) begin
            wr(teac_pkg::CTRL_OFFSET, 32'h0000_041F | (32'(3'(c + 4)) << 6), teac_pkg::RESP_OKAY);
            settle(2);
            chk(vmid_wc, (3'(c + 4) <= teac_pkg::WILDCARD_MAX) ? 3'(c + 4) : 3'h0);
        end
        wr(teac_pkg::ACK_OFFSET, 32'hFFFF_FFFF, teac_pkg::RESP_SLVERR);
        rd(teac_pkg::ACK_OFFSET, d, teac_pkg::RESP_OKAY);
        chk(d, 32'h0000_04DF);
        rd(12'h100, d, teac_pkg::RESP_SLVERR);
        chk(d, 32'h0);
        $display("test enable done");
        @(posedge clk);
        start_op <= 1'b1;
        stall_req <= 1'b1;
        @(posedge clk);
        start_op <= 1'b0;
        stall_req <= 1'b0;
        wr(teac_pkg::CTRL_OFFSET, 32'h0000_04DE, teac_pkg::RESP_OKAY);
        poll(1'b0);
        settle(0);
        chk({op_busy, abort_seen}, 2'h1);
        chk({stall_en, stall_abort, priq_en}, 3'h2);
        chk(route, teac_pkg::TEAC_BYPASS);
        chk({rel_count[7:0], rel_tag}, 16'h015A);
        $display("test disable done");
        test_done;
    end
endmodule : test_translation_enable_and_ack_control
`default_nettype wire
